// file: inc/crb_pkg.sv
package crb_pkg;

    // ****************************************************************
    // Widths
    // ****************************************************************
    localparam int DATA_W = 25;
    localparam int PAIR_W = 14;

    // ****************************************************************
    // Active-input masks, bit n-1 stands for input n
    // ****************************************************************
    localparam logic [24:0] MASK_SINGLE = 25'h1FF_FFB6;
    localparam logic [24:0] MASK_PAIR_A = 25'h000_3FB6;
    localparam logic [24:0] MASK_PAIR_B = 25'h000_1BBF;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [24:0] DATA_RST = 25'h000_0000;
    localparam logic [1:0]  SYNC_RST = 2'h0;

    typedef enum logic [1:0] {
        CRB_SINGLE,
        CRB_PAIR_A,
        CRB_PAIR_B
    } crb_mode_type;

    // Active mask for the current configuration
    function automatic logic [24:0] crb_mask(input crb_mode_type m);
        case (m)
            CRB_SINGLE: crb_mask = MASK_SINGLE;
            CRB_PAIR_A: crb_mask = MASK_PAIR_A;
            CRB_PAIR_B: crb_mask = MASK_PAIR_B;
            default:    crb_mask = MASK_SINGLE;
        endcase
    endfunction : crb_mask

endpackage : crb_pkg

// file: testbench/crb_buffer_chk.sv
`timescale 1ns/1ps
module crb_buffer_chk
    import crb_pkg::*;
(
    // Clock and inputs
    input wire logic        mclk,
    input wire logic        reset_n,
    input wire logic        fanout_mode_select,
    input wire logic        pinout_bank_select,
    input wire logic        device_chip_select_n,
    input wire logic        chip_select_register_n,
    input wire logic [24:0] data_in,
    input wire logic        termination_ctrl_in,
    input wire logic        clock_enable_ctrl_in,
    // Outputs
    input wire logic [24:0] data_out_a,
    input wire logic [24:0] data_out_b,
    input wire logic        chip_select_echo_out,
    input wire logic        termination_ctrl_out,
    input wire logic        clock_enable_ctrl_out
);
    logic [2:0]  cnt_q;
    wire  [24:0] dm = data_in & (!fanout_mode_select ? MASK_SINGLE :
        pinout_bank_select ? MASK_PAIR_B : MASK_PAIR_A);
    wire         ok = cnt_q > 3'h4;
    wire         gt = device_chip_select_n & chip_select_register_n;
    wire  [52:0] q  = {data_out_a, data_out_b, chip_select_echo_out,
        termination_ctrl_out, clock_enable_ctrl_out};
    always_ff @(posedge mclk)
        cnt_q <= !reset_n ? 3'h0 : cnt_q + 3'(cnt_q != 3'h7);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    a_rst_clear: assert property (disable iff (1'b0)
        !reset_n |=> q == 53'h0) else $error("not cleared");
    a_release_low: assert property (
        cnt_q < 3'h4 |-> q == 53'h0) else $error("early output");
    a_data_load: assert property (
        ok && !$past(gt) |-> data_out_a == $past(dm)) else $error("bad load");
    a_gate_hold: assert property (
        ok && $past(gt) |-> $stable(q[52:3])) else $error("not held");
    a_copy_pair: assert property (ok && !$past(gt) |->
        data_out_b == ($past(fanout_mode_select) ? data_out_a : 25'h0))
        else $error("bad copy");
    a_echo_cs: assert property (
        ok |-> chip_select_echo_out == $past(device_chip_select_n))
        else $error("bad echo");
    a_term_pass: assert property (
        ok |-> termination_ctrl_out == $past(termination_ctrl_in))
        else $error("bad term");
    a_cke_pass: assert property (
        ok |-> clock_enable_ctrl_out == $past(clock_enable_ctrl_in))
        else $error("bad cke");
    c_gate: cover property (ok && gt);
    c_pair_a: cover property (ok && fanout_mode_select && !pinout_bank_select);
    c_pair_b: cover property (ok && fanout_mode_select && pinout_bank_select);
endmodule : crb_buffer_chk
bind crb_buffer crb_buffer_chk crb_buffer_chk_i (.*);

// file: testbench/crb_ctrl_model.sv
`timescale 1ns/1ps
module crb_ctrl_model (
    // Clock in, command out
    input  wire logic        mclk,
    output logic      [30:0] cmd
);
    // Inputs held low from time zero
    initial cmd = 31'h0;
    // Levels change only at the falling edge
    task automatic send(input logic [30:0] c);
        @(negedge mclk);
        cmd = c;
    endtask : send
endmodule : crb_ctrl_model

// file: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top
    import crb_pkg::*;
;
    logic mclk = 1'b0, reset_n, fanout_mode_select, pinout_bank_select;
    logic device_chip_select_n, chip_select_register_n, termination_ctrl_in;
    logic clock_enable_ctrl_in, chip_select_echo_out, termination_ctrl_out;
    logic        clock_enable_ctrl_out;
    logic [24:0] data_in, data_out_a, data_out_b;
    logic [30:0] cmd;
    int          num_errors = 0;
    int          n_compared = 0;
    wire  [52:0] q = {data_out_a, data_out_b, chip_select_echo_out,
        termination_ctrl_out, clock_enable_ctrl_out};
    assign {fanout_mode_select, pinout_bank_select, device_chip_select_n,
        chip_select_register_n, termination_ctrl_in, clock_enable_ctrl_in,
        data_in} = cmd;
    crb_ctrl_model crb_ctrl_model_i (.*);
    crb_buffer crb_buffer_i (.*);
    initial begin
        forever #2.5 mclk = ~mclk;
    end
    task automatic chk(input logic [52:0] s, input logic [52:0] e);
        n_compared++;
        if (s !== e) begin
            num_errors++;
            $display("MISMATCH q exp %h seen %h", e, s);
        end
    endtask : chk
    task automatic step(input logic [30:0] c, input logic [52:0] e);
        crb_ctrl_model_i.send(c);
        @(negedge mclk);
        chk(q, e);
    endtask : step
    task automatic t_modes;
        logic [24:0] m [3] = '{MASK_SINGLE, MASK_PAIR_A, MASK_PAIR_B};
        for (int i = 0; i < 3; i++) begin
            step({i != 0, i == 2, 4'h3, 25'h1FF_FFFF},
                {m[i], i != 0 ? m[i] : 25'h0, 3'h3});
        end
    endtask : t_modes
    task automatic t_gate;
        logic [24:0] x = 25'h0AA_AAAA & MASK_SINGLE;
        step({6'h0A, 25'h0AA_AAAA}, {x, 25'h0, 3'h6});
        step({6'h0D, 25'h155_5555}, {x, 25'h0, 3'h5});
        x = 25'h155_5555 & MASK_SINGLE;
        step({6'h06, 25'h155_5555}, {x, 25'h0, 3'h2});
    endtask : t_gate
    task automatic t_reset;
        step({6'h33, 25'h1FF_FFFF}, {MASK_PAIR_B, MASK_PAIR_B, 3'h3});
        crb_ctrl_model_i.send({6'h3C, 25'h1FF_FFFF});
        reset_n = 0;
        @(negedge mclk);
        chk(q, 53'h0);
        crb_ctrl_model_i.send({2'h3, 29'hx});
        @(negedge mclk);
        chk(q, 53'h0);
        crb_ctrl_model_i.send({2'h3, 29'h0});
        reset_n = 1;
        repeat (3) begin
            @(negedge mclk);
            chk(q, 53'h0);
        end
        step({6'h33, 25'h1FF_FFFF}, {MASK_PAIR_B, MASK_PAIR_B, 3'h3});
    endtask : t_reset
    task automatic finish_test;
        if (num_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test
    initial begin
        #20000;
        num_errors++;
        finish_test;
    end
    // Reset held while the clock settles
    initial begin
        reset_n = 0;
        repeat (10) @(negedge mclk);
        reset_n = 1;
        repeat (5) @(negedge mclk);
        t_modes;
        t_gate;
        t_reset;
        finish_test;
    end
endmodule : tb_top

// file: verilog/crb_buffer.sv
`timescale 1ns/1ps
// Notes on behaviour
// [R01] Inputs captured at the clock crossing; outputs hold otherwise.
// [R02] Mode select low: 25-bit single copy; high: 14-bit two copies.
// [R03] Bank select low picks arrangement A, high picks arrangement B.
// [R04] Active input set depends on the mode and arrangement.
// [R05] Only outputs matching active inputs are driven; others stay low.
// [R06] Two-copy mode drives both copies with the same value.
// [R07] Reset clears every flop and forces all outputs low.
// [R08] Inputs are ignored while reset is held.
// [R09] Reset needs no timing relation to clock edges.
// [R10] After release outputs stay low while inputs are low.
// [R11] System holds reset low at power-up until the clock is stable.
// [R12] Both chip selects high freeze the gated data outputs.
// [R13] Either chip select low loads the gated outputs normally.
// [R14] Reset overrides chip-select gating.
// [R15] Chip select register may be tied low when gating is unused.
// [R16] Termination and clock enable register every crossing.
// [R17] Chip select echo follows device chip select every crossing.
module crb_buffer
    import crb_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        reset_n,
    // Configuration
    input  wire logic        fanout_mode_select,
    input  wire logic        pinout_bank_select,
    // Chip selects
    input  wire logic        device_chip_select_n,
    input  wire logic        chip_select_register_n,
    // Data and control inputs
    input  wire logic [24:0] data_in,
    input  wire logic        termination_ctrl_in,
    input  wire logic        clock_enable_ctrl_in,
    // Gated outputs, copy A and copy B
    output logic      [24:0] data_out_a,
    output logic      [24:0] data_out_b,
    // Ungated outputs
    output logic             chip_select_echo_out,
    output logic             termination_ctrl_out,
    output logic             clock_enable_ctrl_out
);

    // ****************************************************************
    // Reset release stage
    // ****************************************************************
    logic rst_sync;
    logic rst_clear;

    // [R09] Reset resynchronised
    crb_sync u_rst_sync (
        .mclk    (mclk),
        .reset_n (reset_n),
        .din     (1'b1),
        .dout    (rst_sync)
    );

    // Entry clears at once, release waits two edges
    // [R10] Held clear after release
    assign rst_clear = !reset_n || !rst_sync;

    // ****************************************************************
    // Input receivers
    // ****************************************************************
    logic [24:0] rx_data;
    logic        rx_dev_cs_n;
    logic        rx_reg_cs_n;
    logic        rx_term;
    logic        rx_cke;

    // Disabled receivers read as low
    // [R08] Receivers off in reset
    always_comb begin
        if (rst_clear) begin
            rx_data     = DATA_RST;
            rx_dev_cs_n = 1'b0;
            rx_reg_cs_n = 1'b0;
            rx_term     = 1'b0;
            rx_cke      = 1'b0;
        end else begin
            rx_data     = data_in;
            rx_dev_cs_n = device_chip_select_n;
            rx_reg_cs_n = chip_select_register_n;
            rx_term     = termination_ctrl_in;
            rx_cke      = clock_enable_ctrl_in;
        end
    end

    // ****************************************************************
    // State
    // ****************************************************************
    // Gated group can freeze, ungated group never does
    typedef struct packed {
        logic [24:0] out_a;
        logic [24:0] out_b;
    } crb_gated_type;

    typedef struct packed {
        logic echo;
        logic term;
        logic cke;
    } crb_ungated_type;

    typedef struct packed {
        crb_gated_type   gated;
        crb_ungated_type ungated;
    } crb_state_type;

    crb_state_type r_q;
    crb_state_type r_d;

    // ****************************************************************
    // Configuration decode
    // ****************************************************************
    logic         two_copy;
    logic         bank_b;
    crb_mode_type mode;
    logic [24:0]  mask;
    logic [24:0]  data_act;
    logic         freeze;
    logic         load_gated;

    // [R02] Fanout mode
    assign two_copy = fanout_mode_select;
    // [R03] Arrangement pick
    assign bank_b   = pinout_bank_select;

    // Mode from the two configuration levels
    always_comb begin
        case ({two_copy, bank_b})
            // Single copy, bank select ignored
            2'h0: begin
                mode = CRB_SINGLE;
            end
            2'h1: begin
                mode = CRB_SINGLE;
            end
            // Two copies, arrangement A
            2'h2: begin
                mode = CRB_PAIR_A;
            end
            // Two copies, arrangement B
            2'h3: begin
                mode = CRB_PAIR_B;
            end
            default: begin
                mode = CRB_SINGLE;
            end
        endcase
    end

    // [R04] Active input set
    assign mask       = crb_mask(mode);
    // Inactive bits are cut by the mask
    assign data_act   = rx_data & mask;
    // [R12] Freeze condition
    assign freeze     = rx_dev_cs_n & rx_reg_cs_n;
    // [R13] Normal load
    assign load_gated = !freeze;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        r_d = r_q;
        // Gated group loads unless frozen
        if (load_gated) begin
            case (mode)
                // [R05] Single copy outputs
                CRB_SINGLE: begin
                    r_d.gated.out_a = data_act;
                    r_d.gated.out_b = DATA_RST;
                end
                // [R06] Both copies, arrangement A
                CRB_PAIR_A: begin
                    r_d.gated.out_a = data_act;
                    r_d.gated.out_b = data_act;
                end
                // [R06] Both copies, arrangement B
                CRB_PAIR_B: begin
                    r_d.gated.out_a = data_act;
                    r_d.gated.out_b = data_act;
                end
                default: begin
                    r_d.gated.out_a = DATA_RST;
                    r_d.gated.out_b = DATA_RST;
                end
            endcase
        end

        // [R16] Ungated controls
        r_d.ungated.term = rx_term;
        r_d.ungated.cke  = rx_cke;
        // [R17] Echo chip select
        r_d.ungated.echo = rx_dev_cs_n;
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    // [R01] Capture on crossing
    always_ff @(posedge mclk) begin
        // [R07] Clear on reset
        // [R14] Reset wins
        if (rst_clear) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Outputs come straight from the state flops
    assign data_out_a            = r_q.gated.out_a;
    assign data_out_b            = r_q.gated.out_b;
    assign chip_select_echo_out  = r_q.ungated.echo;
    assign termination_ctrl_out  = r_q.ungated.term;
    assign clock_enable_ctrl_out = r_q.ungated.cke;

endmodule : crb_buffer

// file: verilog/crb_sync.sv
`timescale 1ns/1ps
module crb_sync
    import crb_pkg::*;
(
    // Clock and reset
    input  wire logic mclk,
    input  wire logic reset_n,
    // Level in and out
    input  wire logic din,
    output logic      dout
);
    typedef struct packed {
        logic s1;
        logic s2;
    } crb_sync_type;

    crb_sync_type r_q;
    crb_sync_type r_d;

    always_comb begin
        r_d    = r_q;
        r_d.s1 = din;
        r_d.s2 = r_q.s1;
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            r_q <= crb_sync_type'(SYNC_RST);
        end else begin
            r_q <= r_d;
        end
    end

    assign dout = r_q.s2;
endmodule : crb_sync
